// file: rtl/cfsel_top.sv
// Frequency select decode, spread and pair options, and first bus clock pin mux.
// Operation
// RULE1: Decode three select inputs into processor frequency; code seven is reserved.
// RULE2: One free bus clock output toggles regardless of any gating.
// RULE3: Spread spectrum supported; default after reset is 0.5 percent down spread.
// RULE4: Pair functions selectable: processor/serial-ref and serial-ref/display 96 MHz.
// RULE5: Serial-ref pair zero can split into two single-ended outputs.
// RULE6: After reset the first multifunction pin drives a bus clock.
// RULE7: Host disables the pin's bus clock before enabling clock request.
// RULE8: Byte five bit seven picks bus clock or clock request input A.
// RULE9: Byte five bit six picks pair zero or pair two for request A.
// RULE10: Request low runs the selected pair; high stops it without runt pulses.
// RULE11: Trusted strap sampled at reset release; pin then becomes bus clock.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module cfsel_top (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pins sampled from outside.
  input  wire logic        cpu_speed_sel_a,
  input  wire logic        cpu_speed_sel_b,
  input  wire logic        cpu_speed_sel_c,
  input  wire logic        clk_request_a_n,
  input  wire logic        trusted_mode_strap,
  // Decoded settings.
  output var  logic [18:0] cpu_freq_khz,
  output var  logic        cpu_freq_reserved,
  output var  logic        overclock_lock,
  output var  logic        ss_enable,
  output var  logic [2:0]  ss_amount,
  output var  logic        cpu_src_pair_sel,
  output var  logic        src_dot_pair_sel,
  output var  logic        serial_ref_pair0_split,
  // Clock outputs and pin enables.
  output var  logic        free_bus_clk_out,
  output var  logic        bus_clk_out0,
  output var  logic        bus_clk_out0_oe,
  output var  logic        bus_clk_out2,
  output var  logic        bus_clk_out2_oe,
  output var  logic        serial_ref_pair0_p,
  output var  logic        serial_ref_pair0_n,
  output var  logic        serial_ref_pair2_p,
  output var  logic        serial_ref_pair2_n
);
  cfsel_pkg::cfsel_cfg_t cfg;
  logic [2:0]  aw_idx;
  logic        aw_bad, aw_full, w_full, ss_touched;
  logic [7:0]  w_byte;
  logic        w_lane;
  logic [2:0]  fs_s1, fs_q;
  logic [1:0]  req_s, strap_s;
  logic [1:0]  strap_cnt;
  logic        strap_done, phase, run0, run2, chk_live;

  // Address decode; anything outside the six used words answers with an error.
  wire [2:0] ar_idx   = s_axi_araddr[4:2];
  wire       ar_hi    = (s_axi_araddr[7:5] != 3'h0);
  wire       w_go     = aw_full && w_full && !s_axi_bvalid;
  wire       wr_spr   = w_go && !aw_bad && aw_idx == cfsel_pkg::REG_SPREAD;
  wire       wr_oen   = w_go && !aw_bad && aw_idx == cfsel_pkg::REG_OUT_EN;
  wire       wr_pfn   = w_go && !aw_bad && aw_idx == cfsel_pkg::REG_PAIRFN;
  wire       wr_crq   = w_go && !aw_bad && aw_idx == cfsel_pkg::REG_CLKREQ;
  wire       wr_hit   = wr_spr || wr_oen || wr_pfn || wr_crq ||
                        (w_go && !aw_bad && aw_idx == cfsel_pkg::REG_FREQ) ||
                        (w_go && !aw_bad && aw_idx == cfsel_pkg::REG_STATUS);
  wire [7:0] status   = {4'h0, run2, run0, cpu_freq_reserved, overclock_lock};
  wire [7:0] freq_rd  = {fs_q, 5'h00};
  logic [7:0] rd_byte;
  logic       rd_ok;
  always_comb begin
    rd_ok   = !ar_hi;
    rd_byte = 8'h00;
    if (ar_hi) begin
      rd_ok = 1'b0;
    end else if (ar_idx == cfsel_pkg::REG_FREQ) begin
      rd_byte = freq_rd;
    end else if (ar_idx == cfsel_pkg::REG_SPREAD) begin
      rd_byte = cfg.spread;
    end else if (ar_idx == cfsel_pkg::REG_OUT_EN) begin
      rd_byte = cfg.out_en;
    end else if (ar_idx == cfsel_pkg::REG_PAIRFN) begin
      rd_byte = cfg.pairfn;
    end else if (ar_idx == cfsel_pkg::REG_CLKREQ) begin
      rd_byte = cfg.clkreq;
    end else if (ar_idx == cfsel_pkg::REG_STATUS) begin
      rd_byte = status;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Write channel: address and data are held until both are in, then one response.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= cfsel_pkg::RESP_OKAY;
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_idx        <= 3'h0;
      aw_bad        <= 1'b0;
      w_byte        <= 8'h00;
      w_lane        <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_idx        <= s_axi_awaddr[4:2];
        aw_bad        <= (s_axi_awaddr[7:5] != 3'h0);
        aw_full       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_byte       <= s_axi_wdata[7:0];
        w_lane       <= s_axi_wstrb[0];
        w_full       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (w_go) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? cfsel_pkg::RESP_OKAY : cfsel_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Configuration bytes; only byte lane zero carries data.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg.spread <= cfsel_pkg::SPREAD_RST; // [RULE3]
      cfg.out_en <= cfsel_pkg::OUT_EN_RST; // [RULE6]
      cfg.pairfn <= cfsel_pkg::PAIRFN_RST;
      cfg.clkreq <= cfsel_pkg::CLKREQ_RST; // [RULE6]
      ss_touched <= 1'b0;
    end else if (w_lane) begin
      if (wr_spr) cfg.spread <= w_byte;
      if (wr_oen) cfg.out_en <= w_byte;
      if (wr_pfn) cfg.pairfn <= w_byte; // [RULE4] [RULE5]
      if (wr_crq) cfg.clkreq <= w_byte; // [RULE8] [RULE9]
      if (wr_spr) ss_touched <= 1'b1;
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= cfsel_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= rd_ok ? cfsel_pkg::RESP_OKAY : cfsel_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Pin synchronisers; only the second stage is read by logic.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fs_s1   <= 3'h0;
      fs_q    <= 3'h0;
      req_s   <= 2'h3;
      strap_s <= 2'h0;
      chk_live <= 1'b0;
    end else begin
      fs_s1   <= {cpu_speed_sel_c, cpu_speed_sel_b, cpu_speed_sel_a};
      fs_q    <= fs_s1;
      req_s   <= {req_s[0], clk_request_a_n};
      strap_s <= {strap_s[0], trusted_mode_strap};
      chk_live <= 1'b1; // Keeps checks off the release edge, where outputs still show reset values.
    end
  end

  // Frequency decode and option outputs follow their sources by one clock.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_freq_khz           <= cfsel_pkg::F_266;
      cpu_freq_reserved      <= 1'b0;
      ss_enable              <= cfsel_pkg::SPREAD_RST[cfsel_pkg::SS_EN_BIT];
      ss_amount              <= cfsel_pkg::SPREAD_RST[3:1];
      cpu_src_pair_sel       <= 1'b0;
      src_dot_pair_sel       <= 1'b0;
      serial_ref_pair0_split <= 1'b0;
    end else begin
      cpu_freq_khz           <= cfsel_pkg::cfsel_freq(fs_q); // [RULE1]
      cpu_freq_reserved      <= (fs_q == cfsel_pkg::FS_RESERVED); // [RULE1]
      ss_enable              <= cfg.spread[cfsel_pkg::SS_EN_BIT]; // [RULE3]
      ss_amount              <= cfg.spread[3:1];
      cpu_src_pair_sel       <= cfg.pairfn[cfsel_pkg::PF_CPU_SRC_BIT]; // [RULE4]
      src_dot_pair_sel       <= cfg.pairfn[cfsel_pkg::PF_SRC_DOT_BIT]; // [RULE4]
      serial_ref_pair0_split <= cfg.pairfn[cfsel_pkg::PF_SPLIT_BIT]; // [RULE5]
    end
  end

  // The strap is caught once the synchroniser has filled after release, then locked.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_cnt      <= 2'h0;
      strap_done     <= 1'b0;
      overclock_lock <= 1'b0;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == cfsel_pkg::STRAP_SETTLE) begin
        strap_done     <= 1'b1;
        overclock_lock <= strap_s[1]; // [RULE11]
      end
    end
  end

  // Request A gates its pair only when enabled and the request pin is high.
  wire cra_en   = cfg.clkreq[cfsel_pkg::CRA_EN_BIT];
  wire cra_sel2 = cfg.clkreq[cfsel_pkg::CRA_SEL_BIT];
  wire stop_req = cra_en && req_s[1]; // [RULE10]
  wire next_ph  = ~phase;
  wire bus0_drv = !cra_en && cfg.out_en[cfsel_pkg::OUTEN_BUS0_BIT]; // [RULE8]

  // Clock outputs toggle each mclk. Run flags only change on the falling half, so a
  // stopped or restarted pair never shows a shortened high phase.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      phase              <= 1'b0;
      run0               <= 1'b1;
      run2               <= 1'b1;
      free_bus_clk_out   <= 1'b0;
      bus_clk_out0       <= 1'b0;
      bus_clk_out0_oe    <= 1'b0;
      bus_clk_out2       <= 1'b0;
      bus_clk_out2_oe    <= 1'b0;
      serial_ref_pair0_p <= 1'b0;
      serial_ref_pair0_n <= 1'b0;
      serial_ref_pair2_p <= 1'b0;
      serial_ref_pair2_n <= 1'b0;
    end else begin
      phase            <= next_ph;
      free_bus_clk_out <= next_ph; // [RULE2]
      if (phase) begin
        run0 <= !(stop_req && !cra_sel2); // [RULE9] [RULE10]
        run2 <= !(stop_req && cra_sel2); // [RULE9] [RULE10]
      end
      bus_clk_out0_oe    <= bus0_drv; // [RULE6] [RULE8]
      bus_clk_out0       <= bus0_drv && next_ph;
      bus_clk_out2_oe    <= strap_done; // [RULE11]
      bus_clk_out2       <= strap_done && next_ph;
      serial_ref_pair0_p <= (phase ? 1'b0 : run0);
      serial_ref_pair0_n <= serial_ref_pair0_split ? (phase ? 1'b0 : run0) :
                            (phase ? run0 : 1'b0); // [RULE5]
      serial_ref_pair2_p <= (phase ? 1'b0 : run2);
      serial_ref_pair2_n <= (phase ? run2 : 1'b0);
    end
  end

  // Checks kept beside the logic.
  sequence s_stop2;
    (cra_en && cra_sel2 && req_s[1])[*3];
  endsequence
  property p_freq;
    @(posedge mclk) disable iff (sys_rst || !chk_live)
      1 |=> cpu_freq_khz == cfsel_pkg::cfsel_freq($past(fs_q));
  endproperty
  a_freq: assert property (p_freq) else $error("Frequency decode mismatch."); // [RULE1]
  property p_free;
    @(posedge mclk) disable iff (sys_rst || !chk_live) ##1 1 |-> free_bus_clk_out != $past(free_bus_clk_out);
  endproperty
  a_free: assert property (p_free) else $error("Free bus clock stalled."); // [RULE2]
  property p_spread;
    @(posedge mclk) disable iff (sys_rst || !chk_live) !ss_touched |=> ss_enable && ss_amount == 3'h0;
  endproperty
  a_spread: assert property (p_spread) else $error("Spread default lost."); // [RULE3]
  property p_pin_out;
    @(posedge mclk) disable iff (sys_rst || !chk_live) cra_en |=> !bus_clk_out0_oe && !bus_clk_out0;
  endproperty
  a_pin_out: assert property (p_pin_out) else $error("Bus clock driven in request mode."); // [RULE8]
  property p_pin_def;
    @(posedge mclk) disable iff (sys_rst || !chk_live)
      !cra_en && cfg.out_en[0] ##1 !cra_en && cfg.out_en[0] |-> bus_clk_out0_oe;
  endproperty
  a_pin_def: assert property (p_pin_def) else $error("Bus clock pin not driven."); // [RULE6]
  property p_stop2;
    @(posedge mclk) disable iff (sys_rst || !chk_live) s_stop2 |=> !serial_ref_pair2_p && !serial_ref_pair2_n;
  endproperty
  a_stop2: assert property (p_stop2) else $error("Pair two not stopped."); // [RULE9]
  property p_run0;
    @(posedge mclk) disable iff (sys_rst || !chk_live)
      (!stop_req)[*3] |=> serial_ref_pair0_p != $past(serial_ref_pair0_p);
  endproperty
  a_run0: assert property (p_run0) else $error("Pair zero not running."); // [RULE10]
  property p_clean;
    @(posedge mclk) disable iff (sys_rst || !chk_live) $rose(serial_ref_pair2_p) |-> free_bus_clk_out;
  endproperty
  a_clean: assert property (p_clean) else $error("Pair two high out of phase."); // [RULE10]
  property p_split;
    @(posedge mclk) disable iff (sys_rst || !chk_live)
      serial_ref_pair0_split ##1 serial_ref_pair0_split |-> serial_ref_pair0_n == serial_ref_pair0_p;
  endproperty
  a_split: assert property (p_split) else $error("Split outputs differ."); // [RULE5]
  property p_strap;
    @(posedge mclk) disable iff (sys_rst || !chk_live)
      strap_done ##1 1 |-> $stable(overclock_lock) && bus_clk_out2_oe;
  endproperty
  a_strap: assert property (p_strap) else $error("Strap lock changed."); // [RULE11]
endmodule : cfsel_top
`default_nettype wire

// file: rtl/cfsel_pkg.sv
// Constants, register map and shared types of the clock select and pin mux block.
package cfsel_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [2:0] REG_FREQ   = 3'h0;
  localparam logic [2:0] REG_SPREAD = 3'h1;
  localparam logic [2:0] REG_OUT_EN = 3'h2;
  localparam logic [2:0] REG_PAIRFN = 3'h3;
  localparam logic [2:0] REG_CLKREQ = 3'h5;
  localparam logic [2:0] REG_STATUS = 3'h6;
  // Field positions.
  localparam int OUTEN_BUS0_BIT = 0;
  localparam int CRA_EN_BIT     = 7;
  localparam int CRA_SEL_BIT    = 6;
  localparam int PF_CPU_SRC_BIT = 0;
  localparam int PF_SRC_DOT_BIT = 1;
  localparam int PF_SPLIT_BIT   = 2;
  localparam int SS_EN_BIT      = 0;
  localparam int FREQ_SEL_LSB   = 5;
  // Reset values; spread code 0 means 0.5 percent down spread.
  localparam logic [7:0] SPREAD_RST = 8'h01;
  localparam logic [7:0] OUT_EN_RST = 8'h01;
  localparam logic [7:0] PAIRFN_RST = 8'h00;
  localparam logic [7:0] CLKREQ_RST = 8'h00;
  // Clocks after release before the strap level has passed the synchroniser.
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  // Processor clock frequencies in kHz.
  localparam logic [18:0] F_266 = 19'h411A4;
  localparam logic [18:0] F_133 = 19'h208D2;
  localparam logic [18:0] F_200 = 19'h30D40;
  localparam logic [18:0] F_166 = 19'h28B04;
  localparam logic [18:0] F_333 = 19'h51612;
  localparam logic [18:0] F_100 = 19'h186A0;
  localparam logic [18:0] F_400 = 19'h61A80;
  localparam logic [18:0] F_RSV = 19'h00000;
  localparam logic [2:0] FS_RESERVED = 3'h7;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Software configuration bytes.
  typedef struct packed {
    logic [7:0] spread;
    logic [7:0] out_en;
    logic [7:0] pairfn;
    logic [7:0] clkreq;
  } cfsel_cfg_t;

  // Decodes the select code {c,b,a} into the processor frequency.
  function automatic logic [18:0] cfsel_freq(input logic [2:0] code);
    case (code)
      3'h0: cfsel_freq = F_266;
      3'h1: cfsel_freq = F_133;
      3'h2: cfsel_freq = F_200;
      3'h3: cfsel_freq = F_166;
      3'h4: cfsel_freq = F_333;
      3'h5: cfsel_freq = F_100;
      3'h6: cfsel_freq = F_400;
      default: cfsel_freq = F_RSV;
    endcase
  endfunction : cfsel_freq
endpackage : cfsel_pkg

// file: dv/cfsel_pin_model.sv
// Far-side pin drivers: frequency select straps, trusted strap and clock request A.
`timescale 1ns/1ps
`default_nettype none
module cfsel_pin_model #(
  parameter logic STRAP_LEVEL = 1'b1
) (
  // Clock.
  input  wire logic mclk,
  // Pins toward the block.
  output var  logic sel_a,
  output var  logic sel_b,
  output var  logic sel_c,
  output var  logic req_n,
  output var  logic strap
);
  // Pins start quiet; the strap holds its level through reset so it can be latched.
  initial begin
    {sel_c, sel_b, sel_a} = 3'h0;
    req_n = 1'b1;
    strap = STRAP_LEVEL;
  end

  // Pin levels move just after an edge, as a board driver would.
  task automatic set_code(input logic [2:0] c);
    @(posedge mclk);
    {sel_c, sel_b, sel_a} <= c;
  endtask : set_code

  // The strap level only counts when reset is released.
  task automatic set_strap(input logic v);
    @(posedge mclk);
    strap <= v;
  endtask : set_strap

  // Low asks for the selected pair to run.
  task automatic set_req(input logic v);
    @(posedge mclk);
    req_n <= v;
  endtask : set_req
endmodule : cfsel_pin_model
`default_nettype wire

// file: dv/cfsel_top_tb_top.sv
// Self-checking testbench of the clock select and pin mux block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got %h expected %h", $time, g, e); end end
module cfsel_top_tb_top;
  localparam logic [1:0] OK = cfsel_pkg::RESP_OKAY;
  localparam logic [1:0] SE = cfsel_pkg::RESP_SLVERR;
  logic        mclk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        sel_a, sel_b, sel_c, req_n, strap, freq_rsv, oc_lock, ss_en;
  logic        cpu_src, src_dot, split, free_clk, b0, b0_oe, b2, b2_oe;
  logic        p0p, p0n, p2p, p2n;
  logic [2:0]  ss_amt;
  logic [3:0]  wstrb;
  logic [18:0] freq;
  int          err_total = 0;
  int          cmp_count = 0;
  // Expected processor frequency in kHz for each select code.
  logic [18:0] khz [8] = '{19'h411A4, 19'h208D2, 19'h30D40, 19'h28B04,
                           19'h51612, 19'h186A0, 19'h61A80, 19'h00000};

  always #12.5 mclk = ~mclk;

  cfsel_pin_model #(.STRAP_LEVEL(1'b1)) pins_u (.mclk(mclk), .sel_a(sel_a), .sel_b(sel_b),
    .sel_c(sel_c), .req_n(req_n), .strap(strap));

  cfsel_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_speed_sel_a(sel_a),
    .cpu_speed_sel_b(sel_b), .cpu_speed_sel_c(sel_c), .clk_request_a_n(req_n),
    .trusted_mode_strap(strap), .cpu_freq_khz(freq), .cpu_freq_reserved(freq_rsv),
    .overclock_lock(oc_lock), .ss_enable(ss_en), .ss_amount(ss_amt), .cpu_src_pair_sel(cpu_src),
    .src_dot_pair_sel(src_dot), .serial_ref_pair0_split(split), .free_bus_clk_out(free_clk),
    .bus_clk_out0(b0), .bus_clk_out0_oe(b0_oe), .bus_clk_out2(b2), .bus_clk_out2_oe(b2_oe),
    .serial_ref_pair0_p(p0p), .serial_ref_pair0_n(p0n), .serial_ref_pair2_p(p2p),
    .serial_ref_pair2_n(p2n));

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // One register write; address and data are dropped at the edge that takes each.
  task automatic wr(input logic [2:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= {3'h0, idx, 2'h0};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (bvalid !== 1'b1) err_total++;
    `CHK(bresp, er)
    // One quiet edge, so a following call never flips bready within one time step.
    @(posedge mclk);
  endtask : wr

  // One register read; only the low byte carries data.
  task automatic rd(input logic [2:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= {3'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (rvalid !== 1'b1) err_total++;
    `CHK(rdata, {24'h000000, d})
    `CHK(rresp, er)
    @(posedge mclk);
  endtask : rd

  // A running pair toggles every cycle; a stopped pair sits with both legs low.
  task automatic run_chk(input logic e0, input logic e2, input logic eb);
    logic a0, a2, af, ab0, ab2;
    @(posedge mclk);
    a0 = p0p;
    a2 = p2p;
    af = free_clk;
    ab0 = b0;
    ab2 = b2;
    @(posedge mclk);
    `CHK(p0p !== a0, e0)
    `CHK(p0p | p0n, e0)
    `CHK(p2p !== a2, e2)
    `CHK(p2p | p2n, e2)
    `CHK(free_clk !== af, 1'b1)
    `CHK(b0 !== ab0, eb)
    `CHK(b2 !== ab2, 1'b1)
  endtask : run_chk

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // Main sequence.
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    tick(4);
    sys_rst <= 1'b0;
    tick(6);
    `CHK(oc_lock, 1'b1)
    `CHK(b2_oe, 1'b1)
    `CHK(b0_oe, 1'b1)
    `CHK({ss_en, ss_amt}, 4'h8)
    rd(cfsel_pkg::REG_SPREAD, 8'h01, OK);
    rd(cfsel_pkg::REG_OUT_EN, 8'h01, OK);
    rd(cfsel_pkg::REG_CLKREQ, 8'h00, OK);
    rd(cfsel_pkg::REG_PAIRFN, 8'h00, OK);
    $display("test reset_defaults done");
    for (int c = 0; c < 8; c++) begin
      pins_u.set_code(c[2:0]);
      tick(6);
      `CHK(freq, khz[c])
      `CHK(freq_rsv, (c == 7))
      rd(cfsel_pkg::REG_FREQ, {c[2:0], 5'h00}, OK);
    end
    $display("test freq_decode done");
    wr(cfsel_pkg::REG_SPREAD, 8'h06, OK);
    tick(2);
    `CHK({ss_en, ss_amt}, 4'h3)
    // A write with lane zero switched off is answered but stores nothing.
    wstrb <= 4'h0;
    wr(cfsel_pkg::REG_SPREAD, 8'h0E, OK);
    wstrb <= 4'hF;
    rd(cfsel_pkg::REG_SPREAD, 8'h06, OK);
    wr(cfsel_pkg::REG_PAIRFN, 8'h07, OK);
    tick(2);
    `CHK({cpu_src, src_dot, split}, 3'h7)
    `CHK(p0n, p0p)
    wr(cfsel_pkg::REG_PAIRFN, 8'h00, OK);
    $display("test options done");
    // Unmapped words answer with an error; the read-only code word ignores writes.
    wr(3'h4, 8'h5A, SE);
    wr(cfsel_pkg::REG_FREQ, 8'h00, OK);
    rd(cfsel_pkg::REG_FREQ, 8'hE0, OK);
    rd(3'h7, 8'h00, SE);
    pins_u.set_code(3'h0);
    $display("test refusals done");
    // A request level is ignored until the pin role is switched.
    pins_u.set_req(1'b1);
    tick(8);
    run_chk(1'b1, 1'b1, 1'b1);
    wr(cfsel_pkg::REG_OUT_EN, 8'h00, OK);
    tick(2);
    `CHK(b0_oe, 1'b0)
    wr(cfsel_pkg::REG_CLKREQ, 8'h80, OK);
    tick(8);
    run_chk(1'b0, 1'b1, 1'b0);
    pins_u.set_req(1'b0);
    tick(8);
    run_chk(1'b1, 1'b1, 1'b0);
    wr(cfsel_pkg::REG_CLKREQ, 8'hC0, OK);
    pins_u.set_req(1'b1);
    tick(8);
    run_chk(1'b1, 1'b0, 1'b0);
    rd(cfsel_pkg::REG_STATUS, 8'h05, OK);
    pins_u.set_req(1'b0);
    wr(cfsel_pkg::REG_CLKREQ, 8'h00, OK);
    wr(cfsel_pkg::REG_OUT_EN, 8'h01, OK);
    tick(2);
    `CHK(b0_oe, 1'b1)
    $display("test clock_request done");
    // A second reset with the strap low must allow overclocking and restore defaults.
    pins_u.set_strap(1'b0);
    sys_rst <= 1'b1;
    tick(4);
    sys_rst <= 1'b0;
    tick(6);
    `CHK(oc_lock, 1'b0)
    `CHK(b2_oe, 1'b1)
    `CHK(b0_oe, 1'b1)
    rd(cfsel_pkg::REG_CLKREQ, 8'h00, OK);
    rd(cfsel_pkg::REG_OUT_EN, 8'h01, OK);
    rd(cfsel_pkg::REG_STATUS, 8'h0C, OK);
    $display("test second_reset done");
    close_out;
  end

  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    close_out;
  end
endmodule : cfsel_top_tb_top
`default_nettype wire
